// ### logic/hpb_pkg.sv
// Package for the host port block: constants, states and carrier structs.
package hpb_pkg;
    // Width of a memory word and of the DMA address.
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    // Address bits decoded from the wide host address bus.
    localparam int WIDE_ADDR_W = 15;
    // Register select codes of the narrow port.
    localparam logic [1:0] SEL_CTRL = 2'h0;
    localparam logic [1:0] SEL_DATA_INC = 2'h1;
    localparam logic [1:0] SEL_ADDR = 2'h2;
    localparam logic [1:0] SEL_DATA_FIX = 2'h3;
    // Field positions inside the control register.
    localparam int CTRL_CORE_INT_BIT = 0;
    localparam int CTRL_HOST_INT_BIT = 1;
    // Reset values.
    localparam logic [WORD_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic KEEPER_RESET = 1'b0;
    // Entries in the buffer in front of the DMA bus.
    localparam int BUF_DEPTH = 2;
    // One request toward the DMA bus.
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } hpb_dma_req_t;
    // Host access sequencer states.
    typedef enum logic [1:0] {
        HPB_IDLE,
        HPB_PUSH,
        HPB_WAIT,
        HPB_DONE
    } hpb_state_t;
endpackage

// ### logic/hpb_top.sv
// Host port block: narrow and wide host access to on-chip memory over DMA.
module hpb_top #(
    parameter int DEPTH = hpb_pkg::BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic host_width_strap,
    input wire logic host_chip_select_n,
    input wire logic host_strobe_one_n,
    input wire logic host_strobe_two_n,
    input wire logic host_read_write,
    input wire logic [1:0] host_register_select,
    input wire logic byte_half_select,
    input wire logic [hpb_pkg::ADDR_W-1:0] host_address_bus,
    input wire logic [hpb_pkg::WORD_W-1:0] host_data_in,
    output logic [hpb_pkg::WORD_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic host_ready_out,
    output logic host_int_n,
    output logic keeper_on,
    output hpb_pkg::hpb_dma_req_t dma_req,
    output logic dma_valid,
    input wire logic dma_ready,
    input wire logic rd_valid,
    input wire logic [hpb_pkg::WORD_W-1:0] rd_data,
    input wire logic core_req,
    input wire logic [hpb_pkg::ADDR_W-1:0] core_addr,
    output logic core_stall,
    input wire logic core_ctrl_wr,
    input wire logic [hpb_pkg::WORD_W-1:0] core_ctrl_wdata,
    output logic [hpb_pkg::WORD_W-1:0] core_ctrl_rd,
    output logic core_event,
    input wire logic core_keeper_wr,
    input wire logic core_keeper_val
);
    import hpb_pkg::*;

    // The shifting buffer below is written for exactly two entries.
    if (DEPTH != 2) begin : g_bad_depth
        $error("hpb_top: DEPTH must be 2");
    end

    hpb_state_t state_r; // Access sequencer state.
    logic wide_r; // Port width taken from the strap during reset.
    logic act_r; // Host strobe seen active last cycle.
    logic [WORD_W-1:0] addr_r; // Host address register.
    logic [7:0] hi_byte_r; // First byte half of a narrow write.
    logic core_int_r; // Host to core interrupt pending.
    logic host_int_r; // Core to host interrupt pending.
    logic keeper_bit_r; // Keeper control bit.
    logic is_read_r; // Current access is a read.
    logic inc_r; // Current access increments the address.
    hpb_dma_req_t cur_r; // Request being handed to the buffer.
    hpb_dma_req_t ent_r [DEPTH]; // Buffer entries; entry 0 is the head.
    logic [DEPTH-1:0] vld_r; // Valid flags of the buffer entries.
    logic act; // Strobe active in this cycle.
    logic start; // First cycle of a host access.
    logic push; // Sequencer hands a request to the buffer.
    logic pop; // DMA bus takes the head entry.

    // Access begins when the chip is selected and either strobe is low.
    assign act = !host_chip_select_n && !(host_strobe_one_n && host_strobe_two_n);
    assign start = act && !act_r && !rst;
    assign push = state_r == HPB_PUSH && !vld_r[DEPTH-1];
    assign pop = vld_r[0] && dma_ready;

    // Decode a narrow data select; used for both reads and writes.
    function automatic logic is_data_sel(input logic [1:0] sel);
        return sel == SEL_DATA_INC || sel == SEL_DATA_FIX;
    endfunction

    // Control register image as both sides see it.
    function automatic logic [WORD_W-1:0] ctrl_image(input logic ci, input logic hi);
        logic [WORD_W-1:0] v;
        v = '0;
        v[CTRL_CORE_INT_BIT] = ci;
        v[CTRL_HOST_INT_BIT] = hi;
        return v;
    endfunction

    // Strap is caught while reset stands; the host may not access then.
    always_ff @(posedge clk) begin
        if (rst) begin
            wide_r <= host_width_strap;
            act_r <= 1'b0;
        end else if (ce) begin
            act_r <= act;
        end
    end

    // Sequencer: turns each wide access and each narrow data fetch or store into one buffered DMA request.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= HPB_IDLE;
            cur_r <= '0;
            is_read_r <= 1'b0;
            inc_r <= 1'b0;
            hi_byte_r <= 8'h00;
        end else if (ce) begin
            case (state_r)
                HPB_IDLE: begin
                    if (start && wide_r) begin
                        // Wide port: every access goes to memory.
                        cur_r.we <= !host_read_write;
                        cur_r.addr <= ADDR_W'(host_address_bus[WIDE_ADDR_W-1:0]);
                        cur_r.wdata <= host_data_in;
                        is_read_r <= host_read_write;
                        inc_r <= 1'b0;
                        state_r <= HPB_PUSH;
                    end else if (start && is_data_sel(host_register_select)) begin
                        // Narrow port: reads fetch on the first half, writes on the second.
                        if (host_read_write && !byte_half_select) begin
                            cur_r.we <= 1'b0;
                            cur_r.addr <= addr_r;
                            is_read_r <= 1'b1;
                            inc_r <= 1'b0;
                            state_r <= HPB_PUSH;
                        end else if (!host_read_write && !byte_half_select) begin
                            hi_byte_r <= host_data_in[7:0];
                            state_r <= HPB_DONE;
                        end else if (!host_read_write) begin
                            cur_r.we <= 1'b1;
                            cur_r.addr <= addr_r;
                            cur_r.wdata <= {hi_byte_r, host_data_in[7:0]};
                            is_read_r <= 1'b0;
                            inc_r <= host_register_select == SEL_DATA_INC;
                            state_r <= HPB_PUSH;
                        end else begin
                            // Second read half is served from the held word.
                            inc_r <= host_register_select == SEL_DATA_INC;
                            is_read_r <= 1'b0;
                            state_r <= HPB_DONE;
                        end
                    end else if (start) begin
                        state_r <= HPB_DONE;
                    end
                end
                HPB_PUSH: begin
                    // A full buffer keeps the host waiting, which is the back-pressure.
                    if (push) begin
                        state_r <= is_read_r ? HPB_WAIT : HPB_DONE;
                    end
                end
                HPB_WAIT: begin
                    if (rd_valid) begin
                        state_r <= HPB_DONE;
                    end
                end
                HPB_DONE: begin
                    if (!act) begin
                        state_r <= HPB_IDLE;
                        inc_r <= 1'b0;
                    end
                end
                default: state_r <= HPB_IDLE;
            endcase
        end
    end

    // Address register: written only by the narrow host, stepped after autoincrement data only.
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= ADDR_RESET;
        end else if (ce) begin
            if (start && !wide_r && host_register_select == SEL_ADDR && !host_read_write) begin
                if (byte_half_select) begin
                    addr_r[7:0] <= host_data_in[7:0];
                end else begin
                    addr_r[15:8] <= host_data_in[7:0];
                end
            end else if (state_r == HPB_DONE && !act && inc_r) begin
                addr_r <= addr_r + 16'h0001;
            end
        end
    end

    // Two-entry buffer; entry 0 always holds the head so outputs are flops.
    always_ff @(posedge clk) begin
        if (rst) begin
            vld_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                ent_r[i] <= '0;
            end
        end else if (ce) begin
            if (pop) begin
                ent_r[0] <= ent_r[1];
                vld_r <= {1'b0, vld_r[DEPTH-1]};
            end
            if (push) begin
                // Land behind the surviving entries.
                if (!vld_r[0] || (pop && !vld_r[1])) begin
                    ent_r[0] <= cur_r;
                    vld_r[0] <= 1'b1;
                end else begin
                    ent_r[1] <= cur_r;
                    vld_r[1] <= 1'b1;
                end
            end
        end
    end
    assign dma_req = ent_r[0];
    assign dma_valid = vld_r[0];

    // Host data bus and ready; data holds its last value between reads.
    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_out <= '0;
            host_data_oe <= 1'b0;
            host_ready_out <= 1'b1;
        end else if (ce) begin
            host_ready_out <= !(start || state_r == HPB_PUSH || state_r == HPB_WAIT);
            if (state_r == HPB_WAIT && rd_valid) begin
                host_data_out <= rd_data;
            end else if (start && !wide_r && host_read_write && byte_half_select
                         && is_data_sel(host_register_select)) begin
                // Only a data select serves the held word; other selects read registers.
                host_data_out <= {8'h00, host_data_out[WORD_W-1:8]};
            end else if (start && !wide_r && host_read_write
                         && host_register_select == SEL_CTRL) begin
                // The control image is read in halves, like the address register.
                host_data_out <= byte_half_select ? {8'h00, core_ctrl_rd[7:0]}
                                                  : {8'h00, core_ctrl_rd[15:8]};
            end else if (start && !wide_r && host_read_write
                         && host_register_select == SEL_ADDR) begin
                host_data_out <= byte_half_select ? {8'h00, addr_r[7:0]}
                                                  : {8'h00, addr_r[15:8]};
            end
            // Narrow word reads present the high half first.
            if (state_r == HPB_WAIT && rd_valid && !wide_r) begin
                host_data_out <= {rd_data[7:0], rd_data[15:8]};
            end
            host_data_oe <= act && host_read_write;
        end
    end

    logic host_ctrl_wr; // Narrow host writes the control register in this cycle.
    assign host_ctrl_wr = start && !wide_r && host_register_select == SEL_CTRL
                          && !host_read_write;

    // Control register: host and core both reach it, wide mode hides it.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_int_r <= 1'b0;
            host_int_r <= 1'b0;
            core_event <= 1'b0;
        end else if (ce) begin
            core_event <= 1'b0;
            // Clears come first so that a set in the same cycle overrides them.
            if (core_ctrl_wr && core_ctrl_wdata[CTRL_CORE_INT_BIT]) begin
                core_int_r <= 1'b0;
            end
            if (host_ctrl_wr && host_data_in[CTRL_HOST_INT_BIT]) begin
                host_int_r <= 1'b0;
            end
            // A set never loses an event to a clear from the other side.
            if (host_ctrl_wr && host_data_in[CTRL_CORE_INT_BIT]) begin
                core_int_r <= 1'b1;
                core_event <= 1'b1;
            end
            if (core_ctrl_wr && core_ctrl_wdata[CTRL_HOST_INT_BIT] && !wide_r) begin
                host_int_r <= 1'b1;
            end
        end
    end
    assign host_int_n = !host_int_r;
    assign core_ctrl_rd = ctrl_image(core_int_r, host_int_r);

    // Keeper control and the clash between host DMA and the core.
    always_ff @(posedge clk) begin
        if (rst) begin
            keeper_bit_r <= KEEPER_RESET;
            core_stall <= 1'b0;
        end else if (ce) begin
            if (core_keeper_wr) begin
                keeper_bit_r <= core_keeper_val;
            end
            core_stall <= pop && core_req && core_addr == ent_r[0].addr;
        end
    end
    assign keeper_on = keeper_bit_r || wide_r;

    a_ready_low_pending: assert property (@(posedge clk) disable iff (rst)
        ce && state_r == HPB_WAIT |=> !host_ready_out) else $error("ready high in read wait");
    a_stall_one_cycle: assert property (@(posedge clk) disable iff (rst)
        ce && pop && core_req && core_addr == ent_r[0].addr |=> core_stall)
        else $error("core not stalled on clash");
    a_keeper_wide_on: assert property (@(posedge clk) disable iff (rst)
        wide_r |-> keeper_on) else $error("keeper off in wide mode");
    a_keeper_reset_off: assert property (@(posedge clk)
        $fell(rst) |-> keeper_bit_r == 1'b0) else $error("keeper bit not cleared");
    a_wide_addr_cut: assert property (@(posedge clk) disable iff (rst)
        wide_r && push |-> cur_r.addr[ADDR_W-1] == 1'b0) else $error("wide address bit 15");
    a_no_ctrl_wide: assert property (@(posedge clk) disable iff (rst)
        ce && wide_r && !core_ctrl_wr |=> !$rose(host_int_r)) else $error("wide ctrl seen");
    a_inc_step: assert property (@(posedge clk) disable iff (rst)
        ce && state_r == HPB_DONE && !act && inc_r |=> addr_r == $past(addr_r) + 16'h0001)
        else $error("address did not step");
    sequence s_wide_start;
        ce && start && wide_r && state_r == HPB_IDLE;
    endsequence
    a_wide_is_dma: assert property (@(posedge clk) disable iff (rst)
        s_wide_start ##1 ce [*2] |-> state_r != HPB_IDLE) else $error("wide access no DMA");
    a_core_event_pulse: assert property (@(posedge clk) disable iff (rst)
        core_event |=> !core_event || $past(ce) == 1'b0) else $error("event not a pulse");
    a_int_set_wins: assert property (@(posedge clk) disable iff (rst)
        ce && host_ctrl_wr && host_data_in[CTRL_CORE_INT_BIT] |=> core_int_r)
        else $error("host set lost to core clear");
endmodule

// ### testbench/hpb_mem_model.sv
// Behavioural on-chip memory that answers the host port's DMA requests.
module hpb_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input hpb_pkg::hpb_dma_req_t dma_req,
    input wire logic dma_valid,
    output logic dma_ready,
    output logic rd_valid,
    output logic [hpb_pkg::WORD_W-1:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import hpb_pkg::*;
    logic [WORD_W-1:0] mem [int]; // Sparse image of the whole RAM.
    logic [ADDR_W-1:0] rq [$]; // Reads accepted but not yet answered.
    int seed = 7; // Own seed, so stalls do not disturb the bench's stream.
    // Take requests in order and answer reads oldest first.
    // Slow mode stalls both the accept and the return at random, as a busy bus would.
    always @(posedge clk) begin
        if (rst) begin
            rq.delete();
            dma_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            if (dma_valid && dma_ready) begin
                if (dma_req.we) begin
                    mem[int'(dma_req.addr)] = dma_req.wdata;
                end else begin
                    rq.push_back(dma_req.addr);
                end
            end
            rd_valid <= 1'b0;
            // A word that is not being returned never keeps its old value.
            rd_data <= ~rd_data;
            if (rq.size() > 0 && (!slow || $random(seed) % 2 != 0)) begin
                rd_valid <= 1'b1;
                rd_data <= mem.exists(int'(rq[0])) ? mem[int'(rq[0])] : 16'hdead;
                void'(rq.pop_front());
            end
            dma_ready <= !slow || $random(seed) % 2 != 0;
        end
    end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench of the host port in its wide and narrow modes.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hpb_pkg::*;
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
        $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
    logic clk = 0, rst = 1, strap = 1, cs_n = 1, s1_n = 1, s2_n = 1, rw = 1, bhs = 0;
    logic [1:0] sel = 0;
    logic [15:0] ha = 0, hdi = 0, hdo, cdat = 0, crd, rdd, caddr = 0, got;
    logic oe, rdy, int_n, keep, dval, dma_ready, rd_valid, cstall, cev, slow = 0;
    logic creq = 0, cwr = 0, kwr = 0, kval = 0, saw_low, ce_in = 1;
    hpb_dma_req_t dreq;
    int fail_count = 0, n_compared = 0, seed = 61, cycles = 0, n_ev = 0, n_st = 0;
    logic [15:0] model [int]; // Expected RAM contents by effective address.

    hpb_top i_dut (.clk(clk), .rst(rst), .ce(ce_in), .host_width_strap(strap),
        .host_chip_select_n(cs_n), .host_strobe_one_n(s1_n), .host_strobe_two_n(s2_n),
        .host_read_write(rw), .host_register_select(sel), .byte_half_select(bhs),
        .host_address_bus(ha), .host_data_in(hdi), .host_data_out(hdo),
        .host_data_oe(oe), .host_ready_out(rdy), .host_int_n(int_n), .keeper_on(keep),
        .dma_req(dreq), .dma_valid(dval), .dma_ready(dma_ready), .rd_valid(rd_valid),
        .rd_data(rdd), .core_req(creq), .core_addr(caddr), .core_stall(cstall),
        .core_ctrl_wr(cwr), .core_ctrl_wdata(cdat), .core_ctrl_rd(crd),
        .core_event(cev), .core_keeper_wr(kwr), .core_keeper_val(kval));
    hpb_mem_model i_mem (.clk(clk), .rst(rst), .slow(slow), .dma_req(dreq),
        .dma_valid(dval), .dma_ready(dma_ready), .rd_valid(rd_valid), .rd_data(rdd));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end
    // Count events and stalls; a hang is cut short well past the expected run.
    always @(posedge clk) begin
        cycles++;
        if (cev) n_ev++;
        if (cstall) n_st++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Prints the totals and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset for three cycles with the width strap held steady throughout.
    task automatic reset_dut(input logic w);
        @(negedge clk);
        rst = 1;
        strap = w;
        repeat (3) @(negedge clk);
        rst = 0;
    endtask
    // One host strobe pulse; held until ready is seen high, then released.
    task automatic acc(input logic r, input logic [1:0] s, input logic b,
                       input logic [15:0] a, input logic [15:0] d);
        int k;
        @(negedge clk);
        cs_n = 0;
        s1_n = 1'($random(seed));
        s2_n = !s1_n;
        rw = r;
        sel = s;
        bhs = b;
        ha = a;
        hdi = d;
        @(negedge clk);
        saw_low = !rdy;
        for (k = 0; k < 60 && rdy !== 1'b1; k++) @(negedge clk);
        got = hdo;
        `CHK(rdy, 1'b1)
        `CHK(oe, r)
        cs_n = 1;
        s1_n = 1;
        s2_n = 1;
        @(negedge clk);
    endtask
    // A narrow word goes as high half first, then low half.
    task automatic nwr(input logic [1:0] s, input logic [15:0] d);
        acc(1'b0, s, 1'b0, 16'h0000, {8'h00, d[15:8]});
        acc(1'b0, s, 1'b1, 16'h0000, {8'h00, d[7:0]});
    endtask
    task automatic nrd(input logic [1:0] s, output logic [15:0] w);
        acc(1'b1, s, 1'b0, 16'h0000, 16'h0000);
        w[15:8] = got[7:0];
        acc(1'b1, s, 1'b1, 16'h0000, 16'h0000);
        w[7:0] = got[7:0];
    endtask
    // Single core write of the control register.
    task automatic core_wr(input logic [15:0] d);
        @(negedge clk);
        cwr = 1;
        cdat = d;
        @(negedge clk);
        cwr = 0;
        @(negedge clk);
    endtask
    // Single core write of the keeper control bit.
    task automatic keep_wr(input logic v);
        @(negedge clk);
        kwr = 1;
        kval = v;
        @(negedge clk);
        kwr = 0;
        @(negedge clk);
    endtask

    initial begin
        int i, n0;
        logic [15:0] a, d, base, w;
        reset_dut(1'b1);
        `CHK(keep, 1'b1)
        `CHK(int_n, 1'b1)
        // Wide port: select inputs are random yet ignored, bit 15 toggled on read.
        for (i = 0; i < 8; i++) begin
            slow = i[0];
            a = 16'($random(seed));
            d = 16'($random(seed));
            creq = (i == 5);
            caddr = {1'b0, a[14:0]};
            acc(1'b0, 2'($random(seed)), 1'($random(seed)), a, d);
            model[int'(a[14:0])] = d;
            `CHK(saw_low, 1'b1)
            acc(1'b1, 2'($random(seed)), 1'($random(seed)), a ^ 16'h8000, 16'h0000);
            `CHK(got, model[int'(a[14:0])])
        end
        creq = 0;
        `CHK(n_st > 0, 1'b1)
        // Set the keeper bit so that the reset below has something to clear.
        keep_wr(1'b1);
        // Narrow port: autoincrement burst, then fixed-address access.
        reset_dut(1'b0);
        `CHK(keep, 1'b0)
        slow = 1;
        base = 16'($random(seed));
        nwr(2'h2, base);
        for (i = 0; i < 4; i++) begin
            w = 16'($random(seed));
            nwr(2'h1, w);
            model[int'(16'(base + i))] = w;
        end
        nwr(2'h2, base);
        for (i = 0; i < 4; i++) begin
            nrd(2'h1, w);
            `CHK(w, model[int'(16'(base + i))])
        end
        a = base + 16'h0002;
        nwr(2'h2, a);
        nwr(2'h3, 16'h5a3c);
        nrd(2'h3, w);
        `CHK(w, 16'h5a3c)
        nrd(2'h3, w);
        `CHK(w, 16'h5a3c)
        // The fixed select leaves the address register where the host put it.
        nrd(2'h2, w);
        `CHK(w, a)
        // Control bits shared between host and core.
        n0 = n_ev;
        nwr(2'h0, 16'h0001);
        `CHK(n_ev - n0, 1)
        `CHK(crd[0], 1'b1)
        nrd(2'h0, w);
        `CHK(w, 16'h0001)
        core_wr(16'h0001);
        `CHK(crd[0], 1'b0)
        core_wr(16'h0002);
        `CHK(int_n, 1'b0)
        nwr(2'h0, 16'h0002);
        `CHK(int_n, 1'b1)
        // A core set while the clock enable is low must not land.
        ce_in = 0;
        core_wr(16'h0002);
        ce_in = 1;
        `CHK(int_n, 1'b1)
        // Keeper bit written by the core.
        keep_wr(1'b1);
        `CHK(keep, 1'b1)
        report_and_stop();
    end
endmodule
